// ### rtl/acq_buf_pkg.sv
// shared types and constants for the acquisition buffer
package acq_buf_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int CNT_W = 24;
	localparam int POS_W = 24;
	localparam int TS_W  = 48;

	typedef logic [CNT_W-1:0]        cnt_t;
	typedef logic signed [POS_W-1:0] pos_t;
	typedef logic [TS_W-1:0]         ts_t;

	// ----------------------------------------------------------------
	// constant values
	// ----------------------------------------------------------------
	localparam cnt_t       CNT_ZERO  = 24'h000000;
	localparam cnt_t       CNT_ONE   = 24'h000001;
	localparam pos_t       POS_UNDEF = 24'hF0BDC1;  // -999999
	localparam ts_t        TS_ZERO   = 48'h000000000000;
	localparam logic [1:0] CMD_SINGLE = 2'h1;
	localparam logic [1:0] CMD_BLOCK  = 2'h2;
	localparam logic [1:0] CMD_ALL    = 2'h3;
	localparam logic [1:0] BLK_BUSY   = 2'h0;
	localparam logic [1:0] BLK_DONE   = 2'h1;
	localparam int         STB_AVAIL_BIT   = 0;
	localparam int         STB_OVERRUN_BIT = 7;
	localparam logic [7:0] STB_RESET       = 8'h00;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		cnt_t scans;
		cnt_t pre;
		logic trig_seen;
		ts_t  trig_ts;
		logic stop_seen;
		pos_t stop_pos;
		ts_t  stop_ts;
		logic end_seen;
		pos_t end_pos;
	} blk_desc_s;

	localparam blk_desc_s DESC_EMPTY = '0;

	typedef enum logic [1:0] {M_SINGLE, M_BLOCK, M_ALL} rd_mode_e;
	typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_SHOW} rd_st_e;

endpackage

// ### rtl/scan_mem.sv
// scan storage ram with registered read data
`timescale 1ns/1ps
module scan_mem #(
	parameter int W      = 64,
	parameter int ADDR_W = 10
) (
	// clock and reset
	input  wire logic              ref_clk_i,
	input  wire logic              rst_n_i,
	// write port
	input  wire logic              wr_en_i,
	input  wire logic [ADDR_W-1:0] wr_addr_i,
	input  wire logic [W-1:0]      wr_data_i,
	// read port
	input  wire logic              rd_en_i,
	input  wire logic [ADDR_W-1:0] rd_addr_i,
	output logic      [W-1:0]      rd_data_o
);
	logic [W-1:0] mem [2**ADDR_W];

	generate
		if (W < 1 || ADDR_W < 1) begin : g_chk
			$error("scan_mem width and address width must be positive");
		end
	endgenerate

	always_ff @(posedge ref_clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			rd_data_o <= '0;
		end else if (rd_en_i) begin
			rd_data_o <= mem[rd_addr_i];
		end
	end
endmodule // scan_mem

// ### rtl/blk_table.sv
// queue of descriptors of completed trigger blocks
`timescale 1ns/1ps
module blk_table import acq_buf_pkg::*; #(
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic      ref_clk_i,
	input  wire logic      rst_n_i,
	// queue ports
	input  wire logic      push_i,
	input  wire blk_desc_s push_desc_i,
	input  wire logic      pop_i,
	output blk_desc_s      head_desc_o,
	output cnt_t           count_o
);
	localparam int PW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (2**PW) != DEPTH) begin : g_chk
			$error("blk_table depth must be a power of two");
		end
	endgenerate

	typedef struct packed {
		blk_desc_s [DEPTH-1:0] slot;
		logic [PW-1:0]         head;
		logic [PW-1:0]         tail;
		cnt_t                  count;
	} tbl_s;

	tbl_s r;
	tbl_s n;

	always_comb begin
		n = r;
		if (push_i) begin
			n.slot[r.tail] = push_desc_i;
			n.tail         = r.tail + 1'b1;
		end
		if (pop_i) begin
			n.head = r.head + 1'b1;
		end
		n.count = r.count + (push_i ? CNT_ONE : CNT_ZERO) - (pop_i ? CNT_ONE : CNT_ZERO);
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign head_desc_o = r.slot[r.head];
	assign count_o     = r.count;
endmodule // blk_table

// ### rtl/acq_buffer.sv
// circular acquisition buffer with trigger blocks, readout and overrun
`timescale 1ns/1ps
module acq_buffer import acq_buf_pkg::*; #(
	parameter int CH        = 4,
	parameter int SAMPLE_W  = 16,
	parameter int ADDR_W    = 10,
	parameter int BLK_DEPTH = 8
) (
	// clock and reset
	input  wire logic                   ref_clk_i,
	input  wire logic                   rst_n_i,
	// acquisition side, one strobe per scan
	input  wire logic                   acq_valid_i,
	input  wire logic [CH*SAMPLE_W-1:0] acq_data_i,
	input  wire logic                   acq_blk_start_i,
	input  wire logic                   acq_trig_i,
	input  wire logic                   acq_stop_i,
	input  wire logic                   acq_end_i,
	input  wire ts_t                    acq_ts_i,
	// host read commands
	input  wire logic                   cmd_valid_i,
	input  wire logic [1:0]             cmd_code_i,
	output logic                        cmd_ready_o,
	output logic                        cmd_done_o,
	// scan readout, signed sample per channel
	output logic                        scan_valid_o,
	output logic [CH*SAMPLE_W-1:0]      scan_data_o,
	input  wire logic                   scan_ready_i,
	// buffer status query fields
	output cnt_t                        stat_blocks_o,
	output cnt_t                        stat_scans_o,
	output pos_t                        stat_read_pos_o,
	output ts_t                         stat_trig_ts_o,
	output pos_t                        stat_stop_pos_o,
	output ts_t                         stat_stop_ts_o,
	output pos_t                        stat_end_pos_o,
	output logic [1:0]                  stat_blk_state_o,
	// status summary byte
	input  wire logic                   status_summary_byte_read_i,
	output logic [7:0]                  status_summary_byte_o,
	output logic                        overrun_o
);
	localparam int   DEPTH     = 2**ADDR_W;
	localparam cnt_t DEPTH_CNT = cnt_t'(DEPTH);

	generate
		if (ADDR_W < 1 || ADDR_W >= CNT_W || CH < 1 || SAMPLE_W < 2) begin : g_chk
			$error("acq_buffer parameters out of range");
		end
	endgenerate

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		rd_st_e            st;
		rd_mode_e          mode;
		logic [ADDR_W-1:0] wr_addr;
		logic [ADDR_W-1:0] rd_addr;
		cnt_t              avail;
		cnt_t              head_read;
		cnt_t              rem;
		logic              live_act;
		blk_desc_s         live;
		logic              done;
		logic              scan_valid;
		logic              overrun;
		logic [7:0]        stb;
		cnt_t              s_blocks;
		cnt_t              s_scans;
		pos_t              s_rpos;
		ts_t               s_tts;
		pos_t              s_stop;
		ts_t               s_sts;
		pos_t              s_end;
		logic [1:0]        s_bstat;
	} acq_s;

	acq_s r;
	acq_s n;

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic      mem_wr;
	logic      mem_rd;
	logic      tbl_push;
	logic      tbl_pop;
	blk_desc_s tbl_head;
	cnt_t      tbl_cnt;

	scan_mem #(
		.W      (CH*SAMPLE_W),
		.ADDR_W (ADDR_W)
	) u_mem (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.wr_en_i   (mem_wr),
		.wr_addr_i (r.wr_addr),
		.wr_data_i (acq_data_i),
		.rd_en_i   (mem_rd),
		.rd_addr_i (r.rd_addr),
		.rd_data_o (scan_data_o)
	);

	blk_table #(
		.DEPTH (BLK_DEPTH)
	) u_tbl (
		.ref_clk_i   (ref_clk_i),
		.rst_n_i     (rst_n_i),
		.push_i      (tbl_push),
		.push_desc_i (n.live),
		.pop_i       (tbl_pop),
		.head_desc_o (tbl_head),
		.count_o     (tbl_cnt)
	);

	// position of a scan relative to its block's trigger scan
	function automatic pos_t rel_pos(input cnt_t idx, input cnt_t pre);
		rel_pos = pos_t'(idx - pre);
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	blk_desc_s head;
	cnt_t      head_left;
	cnt_t      nblk;
	cnt_t      er;
	cnt_t      rem0;
	logic      full;
	logic      wr_ok;
	logic      ovr;

	always_comb begin
		n         = r;
		mem_wr    = 1'b0;
		mem_rd    = 1'b0;
		tbl_push  = 1'b0;
		tbl_pop   = 1'b0;
		n.done    = 1'b0;
		head      = (tbl_cnt != CNT_ZERO) ? tbl_head : r.live;
		head_left = head.scans - r.head_read;
		nblk      = tbl_cnt + (r.live_act ? CNT_ONE : CNT_ZERO);
		wr_ok     = acq_valid_i && (r.live_act || acq_blk_start_i);
		full      = (r.avail == DEPTH_CNT);
		ovr       = wr_ok && full;
		er        = CNT_ZERO;
		rem0      = CNT_ZERO;

		// readout; a scan write into a full buffer has priority over a fetch
		case (r.st)
			ST_IDLE: begin
				if (cmd_valid_i) begin
					case (cmd_code_i)
						CMD_SINGLE: begin
							n.mode = M_SINGLE;
							rem0   = CNT_ONE;
						end
						CMD_BLOCK: begin
							n.mode = M_BLOCK;
							// only a completed block may be read as a block
							rem0   = (tbl_cnt != CNT_ZERO) ? head_left : CNT_ZERO;
						end
						CMD_ALL: begin
							n.mode = M_ALL;
							rem0   = r.avail;
						end
						default: begin
							n.mode = M_SINGLE;
							rem0   = CNT_ZERO;
						end
					endcase
					n.rem = rem0;
					if (rem0 != CNT_ZERO && r.avail != CNT_ZERO) begin
						n.st = ST_FETCH;
					end else begin
						n.done = 1'b1;
					end
				end
			end
			ST_FETCH: begin
				if (r.rem == CNT_ZERO || r.avail == CNT_ZERO) begin
					n.st   = ST_IDLE;
					n.done = 1'b1;
				end else if (!ovr) begin
					mem_rd       = 1'b1;
					n.rd_addr    = r.rd_addr + 1'b1;
					n.avail      = r.avail - CNT_ONE;
					n.head_read  = r.head_read + CNT_ONE;
					n.rem        = r.rem - CNT_ONE;
					n.scan_valid = 1'b1;
					n.st         = ST_SHOW;
					if (head_left == CNT_ONE && tbl_cnt != CNT_ZERO) begin
						tbl_pop     = 1'b1;
						n.head_read = CNT_ZERO;
					end
				end
			end
			ST_SHOW: begin
				if (scan_ready_i) begin
					n.scan_valid = 1'b0;
					if (r.rem == CNT_ZERO || r.avail == CNT_ZERO) begin
						n.st   = ST_IDLE;
						n.done = 1'b1;
					end else begin
						n.st = ST_FETCH;
					end
				end
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase

		// overrun: make room for the incoming scan before it is stored
		if (ovr) begin
			n.overrun = 1'b1;
			if (nblk <= CNT_ONE) begin
				if (r.head_read < head.pre && head.trig_seen) begin
					er = head.pre - r.head_read;
				end else begin
					er = CNT_ONE;
				end
				n.head_read = r.head_read + er;
			end else begin
				er          = head_left;
				tbl_pop     = 1'b1;
				n.head_read = CNT_ZERO;
				if (r.mode == M_BLOCK) begin
					n.rem = CNT_ZERO;
				end
			end
			n.rd_addr = r.rd_addr + er[ADDR_W-1:0];
			n.avail   = r.avail - er;
		end

		// acquisition keeps its pace whatever the reader does
		if (wr_ok) begin
			mem_wr    = 1'b1;
			n.wr_addr = r.wr_addr + 1'b1;
			n.avail   = n.avail + CNT_ONE;
			if (acq_blk_start_i) begin
				n.live     = DESC_EMPTY;
				n.live_act = 1'b1;
			end
			if (!n.live.trig_seen && !acq_trig_i) begin
				n.live.pre = n.live.pre + CNT_ONE;
			end
			if (acq_trig_i) begin
				n.live.trig_seen = 1'b1;
				n.live.trig_ts   = acq_ts_i;
			end
			if (acq_stop_i) begin
				n.live.stop_seen = 1'b1;
				n.live.stop_pos  = rel_pos(n.live.scans, n.live.pre);
				n.live.stop_ts   = acq_ts_i;
			end
			if (acq_end_i) begin
				n.live.end_seen = 1'b1;
				n.live.end_pos  = rel_pos(n.live.scans, n.live.pre);
				n.live_act      = 1'b0;
				tbl_push        = 1'b1;
			end
			n.live.scans = n.live.scans + CNT_ONE;
		end

		// status fields, registered; besides the block and scan counts they describe the current head block
		n.s_blocks = nblk;
		n.s_scans  = r.avail;
		if (nblk == CNT_ZERO || r.avail == CNT_ZERO) begin
			n.s_rpos = POS_UNDEF;
		end else begin
			n.s_rpos = rel_pos(r.head_read, head.pre);
		end
		if (nblk == CNT_ZERO) begin
			n.s_tts   = TS_ZERO;
			n.s_stop  = POS_UNDEF;
			n.s_sts   = TS_ZERO;
			n.s_end   = POS_UNDEF;
			n.s_bstat = BLK_BUSY;
		end else begin
			n.s_tts   = head.trig_seen ? head.trig_ts : TS_ZERO;
			n.s_stop  = head.stop_seen ? head.stop_pos : POS_UNDEF;
			n.s_sts   = head.stop_seen ? head.stop_ts : TS_ZERO;
			n.s_end   = head.end_seen ? head.end_pos : POS_UNDEF;
			n.s_bstat = (tbl_cnt != CNT_ZERO) ? BLK_DONE : BLK_BUSY;
		end

		// sticky overrun; a new overrun beats a simultaneous read
		if (status_summary_byte_read_i && !ovr) begin
			n.overrun = 1'b0;
		end
		n.stb                  = STB_RESET;
		n.stb[STB_OVERRUN_BIT] = n.overrun;
		n.stb[STB_AVAIL_BIT]   = (n.avail != CNT_ZERO);
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			r          <= '0;
			r.st       <= ST_IDLE;
			r.mode     <= M_SINGLE;
			r.live     <= DESC_EMPTY;
			r.stb      <= STB_RESET;
			r.s_rpos   <= POS_UNDEF;
			r.s_stop   <= POS_UNDEF;
			r.s_end    <= POS_UNDEF;
			r.s_bstat  <= BLK_BUSY;
		end else begin
			r <= n;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign cmd_ready_o           = (r.st == ST_IDLE);
	assign cmd_done_o            = r.done;
	assign scan_valid_o          = r.scan_valid;
	assign stat_blocks_o         = r.s_blocks;
	assign stat_scans_o          = r.s_scans;
	assign stat_read_pos_o       = r.s_rpos;
	assign stat_trig_ts_o        = r.s_tts;
	assign stat_stop_pos_o       = r.s_stop;
	assign stat_stop_ts_o        = r.s_sts;
	assign stat_end_pos_o        = r.s_end;
	assign stat_blk_state_o      = r.s_bstat;
	assign status_summary_byte_o = r.stb;
	assign overrun_o             = r.overrun;
endmodule // acq_buffer

// ### verif/acq_buffer_monitor.sv
// concurrent checks on the acquisition buffer ports
`timescale 1ns/1ps
module acq_buffer_monitor import acq_buf_pkg::*; #(
	parameter int CH       = 4,
	parameter int SAMPLE_W = 16,
	parameter int ADDR_W   = 10
) (
	// clock and reset
	input wire logic                   ref_clk_i,
	input wire logic                   rst_n_i,
	// stream side
	input wire logic                   acq_valid_i,
	input wire logic                   scan_valid_o,
	input wire logic                   scan_ready_i,
	input wire logic [CH*SAMPLE_W-1:0] scan_data_o,
	// status side
	input wire cnt_t                   stat_blocks_o,
	input wire cnt_t                   stat_scans_o,
	input wire pos_t                   stat_read_pos_o,
	input wire ts_t                    stat_trig_ts_o,
	input wire pos_t                   stat_end_pos_o,
	input wire logic [1:0]             stat_blk_state_o,
	input wire logic                   status_summary_byte_read_i,
	input wire logic [7:0]             status_summary_byte_o,
	input wire logic                   overrun_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	// poll with no scan arriving, so no fresh overrun can win
	sequence s_poll_quiet;
		status_summary_byte_read_i && !acq_valid_i ##1 !acq_valid_i;
	endsequence
	sequence s_ovr_hold;
		overrun_o && !status_summary_byte_read_i && !$past(status_summary_byte_read_i);
	endsequence

	a_empty_undef: assert property (stat_blocks_o == CNT_ZERO |->
		stat_scans_o == CNT_ZERO && stat_read_pos_o == POS_UNDEF
		&& stat_trig_ts_o == TS_ZERO && stat_end_pos_o == POS_UNDEF)
		else $error("empty buffer status fields wrong");
	a_stb_bits: assert property (status_summary_byte_o[STB_OVERRUN_BIT] == overrun_o
		&& status_summary_byte_o[6:1] == 6'h00)
		else $error("status byte bits wrong");
	a_ovr_sticky: assert property (s_ovr_hold |=> overrun_o)
		else $error("overrun bit dropped without a poll");
	a_poll_clear: assert property (s_poll_quiet |=> !overrun_o)
		else $error("overrun bit not cleared by status read");
	a_ovr_cause: assert property ($rose(overrun_o) |-> $past(acq_valid_i, 1))
		else $error("overrun without an incoming scan");
	a_scan_hold: assert property (scan_valid_o && !scan_ready_i && !acq_valid_i |=>
		scan_valid_o && $stable(scan_data_o))
		else $error("scan withdrawn before accepted");
	a_scan_limit: assert property (stat_scans_o <= (1 << ADDR_W))
		else $error("scan count beyond capacity");
	a_done_end: assert property (stat_blk_state_o == BLK_DONE |->
		stat_end_pos_o != POS_UNDEF)
		else $error("complete block without end position");
endmodule // acq_buffer_monitor

// ### verif/host_model.sv
// host computer model taking scans from the buffer
`timescale 1ns/1ps
module host_model #(
	parameter int W = 64
) (
	// clock and reset
	input  wire logic         ref_clk_i,
	input  wire logic         rst_n_i,
	// scan stream
	input  wire logic         scan_valid_i,
	input  wire logic [W-1:0] scan_data_i,
	input  wire logic         slow_i,
	output logic              scan_ready_o
);
	logic         ph_r;
	logic [W-1:0] rx[$];
	// slow host takes a scan only every other cycle
	assign scan_ready_o = scan_valid_i & (~slow_i | ph_r);
	always @(posedge ref_clk_i) begin
		ph_r <= ~ph_r & rst_n_i;
		if (rst_n_i && scan_valid_i && scan_ready_o)
			rx.push_back(scan_data_i);
	end
endmodule // host_model

// ### verif/tb_acquisition_buffer_readout.sv
// testbench for the acquisition buffer readout
`timescale 1ns/1ps
module tb_acquisition_buffer_readout import acq_buf_pkg::*;;
	logic        ref_clk_i, rst_n_i, acq_valid_i, acq_blk_start_i, acq_trig_i;
	logic        acq_stop_i, acq_end_i, cmd_valid_i, cmd_ready_o, cmd_done_o;
	logic        scan_valid_o, scan_ready_i, slow, status_summary_byte_read_i, overrun_o;
	logic [63:0] acq_data_i, scan_data_o;
	logic [1:0]  cmd_code_i, stat_blk_state_o;
	logic [7:0]  status_summary_byte_o;
	logic [15:0] seq;
	ts_t         acq_ts_i, stat_trig_ts_o, stat_stop_ts_o;
	cnt_t        stat_blocks_o, stat_scans_o;
	pos_t        stat_read_pos_o, stat_stop_pos_o, stat_end_pos_o;
	int          failures, check_count, cyc;

	acq_buffer #(.ADDR_W(3)) DUT (.ref_clk_i, .rst_n_i, .acq_valid_i, .acq_data_i,
		.acq_blk_start_i, .acq_trig_i, .acq_stop_i, .acq_end_i, .acq_ts_i,
		.cmd_valid_i, .cmd_code_i, .cmd_ready_o, .cmd_done_o, .scan_valid_o,
		.scan_data_o, .scan_ready_i, .stat_blocks_o, .stat_scans_o, .stat_read_pos_o,
		.stat_trig_ts_o, .stat_stop_pos_o, .stat_stop_ts_o, .stat_end_pos_o,
		.stat_blk_state_o, .status_summary_byte_read_i, .status_summary_byte_o, .overrun_o);
	host_model host (.ref_clk_i, .rst_n_i, .scan_valid_i(scan_valid_o),
		.scan_data_i(scan_data_o), .slow_i(slow), .scan_ready_o(scan_ready_i));

	// ----
	// helpers
	// ----
	task tick;
		@(posedge ref_clk_i);
		#1;
	endtask
	function logic [63:0] dat(logic [15:0] k);
		return {4{k}};
	endfunction
	task chk(string nm, logic [63:0] e, logic [63:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task end_of_test;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// flags are start, trigger, stop, end
	task wr(logic [3:0] f, ts_t ts);
		seq++;
		acq_valid_i = 1;
		{acq_blk_start_i, acq_trig_i, acq_stop_i, acq_end_i} = f;
		acq_data_i = dat(seq);
		acq_ts_i = ts;
		tick;
	endtask
	// status outputs lag, so let a few edges pass
	task wend;
		acq_valid_i = 0;
		repeat (3) tick;
	endtask
	task st(cnt_t b, cnt_t s, pos_t r, logic [1:0] k);
		chk("blocks", b, stat_blocks_o);
		chk("scans", s, stat_scans_o);
		chk("read_pos", r, stat_read_pos_o);
		chk("blk_state", k, stat_blk_state_o);
	endtask
	task cmd(logic [1:0] c, int n, logic [15:0] f);
		int i;
		host.rx.delete();
		cmd_code_i = c;
		cmd_valid_i = 1;
		while (cmd_ready_o !== 1'b1) tick;
		tick;
		cmd_valid_i = 0;
		i = 0;
		while (cmd_done_o !== 1'b1 && i < 300) begin
			tick;
			i++;
		end
		chk("done", 64'h1, 64'(i < 300));
		repeat (3) tick;
		chk("count", 64'(n), 64'(host.rx.size()));
		if (n > 0) begin
			chk("first", dat(f), host.rx[0]);
			chk("last", dat(16'(f + n - 1)), host.rx[n-1]);
		end
	endtask
	task poll;
		status_summary_byte_read_i = 1;
		tick;
		status_summary_byte_read_i = 0;
		repeat (3) tick;
	endtask

	// ----
	// scenarios
	// ----
	task t_empty;
		st(24'h0, 24'h0, POS_UNDEF, BLK_BUSY);
		chk("trig_ts", TS_ZERO, stat_trig_ts_o);
		chk("stop_pos", POS_UNDEF, stat_stop_pos_o);
		chk("stop_ts", TS_ZERO, stat_stop_ts_o);
		chk("end_pos", POS_UNDEF, stat_end_pos_o);
	endtask
	task t_single;
		wr(4'h8, 48'h0);
		wr(4'h0, 48'h0);
		wr(4'h4, 48'hA1);
		wr(4'h2, 48'hA2);
		wr(4'h1, 48'h0);
		wr(4'h8, 48'h0);
		wr(4'h6, 48'hB3);
		wr(4'h1, 48'h0);
		wend;
		st(24'h2, 24'h8, -24'sh2, BLK_DONE);
		chk("trig_ts", 48'hA1, stat_trig_ts_o);
		chk("stop_pos", 24'h1, stat_stop_pos_o);
		chk("stop_ts", 48'hA2, stat_stop_ts_o);
		chk("end_pos", 24'h2, stat_end_pos_o);
		cmd(CMD_SINGLE, 1, 16'h1);
		st(24'h2, 24'h7, -24'sh1, BLK_DONE);
	endtask
	task t_block;
		slow = 1;
		cmd(CMD_BLOCK, 4, 16'h2);
		slow = 0;
		st(24'h1, 24'h3, -24'sh1, BLK_DONE);
		chk("trig_ts", 48'hB3, stat_trig_ts_o);
		chk("stop_pos", 24'h0, stat_stop_pos_o);
		chk("end_pos", 24'h1, stat_end_pos_o);
	endtask
	task t_multi;
		for (int i = 0; i < 3; i++) begin
			wr(4'h8, 48'h0);
			wr(4'h6, 48'(16'h100 + i));
			wr(4'h1, 48'h0);
		end
		wend;
		st(24'h2, 24'h6, -24'sh1, BLK_DONE);
		chk("trig_ts", 48'h101, stat_trig_ts_o);
		chk("overrun", 64'h1, overrun_o);
		chk("stb", 8'h81, status_summary_byte_o);
		repeat (5) tick;
		chk("overrun_kept", 64'h1, overrun_o);
		poll;
		chk("overrun_clr", 64'h0, overrun_o);
		cmd(CMD_ALL, 6, 16'hC);
	endtask
	task t_one;
		wr(4'h8, 48'h0);
		wr(4'h0, 48'h0);
		wr(4'h4, 48'hC4);
		repeat (6) wr(4'h0, 48'h0);
		wend;
		st(24'h1, 24'h7, 24'h0, BLK_BUSY);
		cmd(CMD_BLOCK, 0, 16'h0);
		wr(4'h1, 48'h0);
		wend;
		st(24'h1, 24'h8, 24'h0, BLK_DONE);
		chk("end_pos", 24'h7, stat_end_pos_o);
		cmd(CMD_ALL, 8, 16'h14);
		poll;
		t_empty;
	endtask

	initial begin
		ref_clk_i = 0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			end_of_test;
		end
	end
	initial begin
		{acq_valid_i, acq_blk_start_i, acq_trig_i, acq_stop_i, acq_end_i} = '0;
		{cmd_valid_i, status_summary_byte_read_i, slow} = '0;
		acq_data_i = '0;
		acq_ts_i = '0;
		cmd_code_i = '0;
		seq = '0;
		rst_n_i = 0;
		repeat (4) @(posedge ref_clk_i);
		#1;
		rst_n_i = 1;
		tick;
		t_empty;
		t_single;
		t_block;
		cmd(CMD_ALL, 3, 16'h6);
		t_empty;
		t_multi;
		t_one;
		end_of_test;
	end
endmodule // tb_acquisition_buffer_readout

bind acq_buffer acq_buffer_monitor #(.CH(CH), .SAMPLE_W(SAMPLE_W), .ADDR_W(ADDR_W)) mon (
	.ref_clk_i, .rst_n_i, .acq_valid_i, .scan_valid_o, .scan_ready_i, .scan_data_o,
	.stat_blocks_o, .stat_scans_o, .stat_read_pos_o, .stat_trig_ts_o, .stat_end_pos_o,
	.stat_blk_state_o, .status_summary_byte_read_i, .status_summary_byte_o, .overrun_o);
